// ---- core/dma_chan_map.vh ----
`ifndef DMA_CHAN_MAP_VH
`define DMA_CHAN_MAP_VH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define OFS_EVT 4'h0
`define OFS_SSA 4'h1
`define OFS_DSA 4'h2
`define OFS_SSIZ 4'h3
`define OFS_DSIZ 4'h4
`define OFS_CSIZ 4'h5
`define OFS_CTRL 4'h6
`define OFS_SPTR 4'h7
`define OFS_DPTR 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EVT_IE_LSB 16
`define EVT_IE_MSB 23
`define EVT_FL_MSB 7
`define BIT_SRC_DONE 7
`define BIT_SRC_HALF 6
`define BIT_DST_DONE 5
`define BIT_DST_HALF 4
`define BIT_BLOCK 3
`define BIT_CELL 2
`define BIT_ABORT 1
`define BIT_ADDR_ERR 0
`define CTRL_ON 0
`define CTRL_IRQ_ABT 1
`define CTRL_PAT_ABT 2
`define CTRL_AIRQ_LSB 8
`define CTRL_AIRQ_MSB 15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ZERO32 32'h0000_0000
`define RST_ZERO16 16'h0000
`define RST_ZERO8 8'h00
`define RST_AIRQ 8'hff

`endif

// ---- core/dma_chan_events.v ----
`timescale 1ns/100ps
`include "dma_chan_map.vh"

// Notes on behaviour
// - Eight interrupt enables sit in bits 23..16, one enables each event.
// - Eight matching event flags sit in bits 7..0; zero means none pending.
// - Source done flag sets when source pointer reaches source size.
// - Source half flag sets when source pointer reaches half source size.
// - Destination done flag sets when destination pointer reaches destination size.
// - Destination half flag sets when pointer reaches half destination size.
// - Block flag sets after larger size moved, or on pattern match.
// - Cell flag sets each time cell-size bytes have been moved.
// - Abort flag sets when selected abort IRQ aborts the running transfer.
// - Address error flag sets when source or destination address is invalid.
// - Unused event register bits read zero; enables and flags reset zero.
// - Source and destination start addresses are 32-bit read/write, reset zero.
// - With IRQ abort enabled, a matching IRQ number aborts the transfer.
// - With pattern abort enabled, a pattern match aborts and clears channel on.
// - Cell size is the byte count moved per start event.
module dma_chan_events (
	input wire clk_sys,
	input wire arst_n,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire start_evt,
	input wire byte_moved,
	input wire irq_evt,
	input wire [7:0] irq_num,
	input wire pattern_hit,
	input wire addr_invalid,
	output reg busy,
	output reg abort_pulse,
	output reg [31:0] src_addr_out,
	output reg [31:0] dst_addr_out,
	output reg chan_irq
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] ie_reg;
	reg [7:0] flag_reg;
	reg [31:0] ssa_reg;
	reg [31:0] dsa_reg;
	reg [15:0] ssiz_reg;
	reg [15:0] dsiz_reg;
	reg [15:0] csiz_reg;
	reg on_reg;
	reg irq_abt_reg;
	reg pat_abt_reg;
	reg [7:0] airq_reg;
	reg [15:0] sptr_reg;
	reg [15:0] dptr_reg;
	reg [15:0] cptr_reg;
	reg [16:0] moved_reg;
	reg active_reg;
	wire [7:0] flag_next;
	reg state_next;
	reg [31:0] rdata_next;

	wire wr_evt = reg_wr && (reg_addr == `OFS_EVT);
	wire wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	// Zero size means 65536 bytes, so sizes are widened by one bit
	wire [16:0] ssiz_full = (ssiz_reg == `RST_ZERO16) ? 17'h1_0000 : {1'b0, ssiz_reg};
	wire [16:0] dsiz_full = (dsiz_reg == `RST_ZERO16) ? 17'h1_0000 : {1'b0, dsiz_reg};
	wire [16:0] csiz_full = (csiz_reg == `RST_ZERO16) ? 17'h1_0000 : {1'b0, csiz_reg};
	wire [16:0] big_full = (ssiz_full > dsiz_full) ? ssiz_full : dsiz_full;
	wire step = active_reg && byte_moved;
	wire [16:0] sptr_inc = {1'b0, sptr_reg} + 17'h0_0001;
	wire [16:0] dptr_inc = {1'b0, dptr_reg} + 17'h0_0001;
	wire [16:0] cptr_inc = {1'b0, cptr_reg} + 17'h0_0001;
	wire [16:0] moved_inc = moved_reg + 17'h0_0001;
	wire src_done = step && (sptr_inc == ssiz_full);
	wire src_half = step && (sptr_inc == {1'b0, ssiz_full[16:1]});
	wire dst_done = step && (dptr_inc == dsiz_full);
	wire dst_half = step && (dptr_inc == {1'b0, dsiz_full[16:1]});
	wire cell_done = step && (cptr_inc == csiz_full);
	wire blk_size = step && (moved_inc == big_full);
	wire pat_abort = active_reg && pat_abt_reg && pattern_hit;
	wire blk_done = blk_size || (active_reg && pattern_hit);
	wire irq_abort = active_reg && irq_abt_reg && irq_evt && (irq_num == airq_reg);
	wire addr_err = active_reg && addr_invalid;
	wire stop = blk_done || irq_abort || addr_err;
	wire end_blk = pat_abort || stop;

	// ----------------------------------------
	// Flags and enables, one slice per event
	// ----------------------------------------
	// Set wins over a software clear in the same cycle, so no event is lost
	wire [7:0] evt_set = {src_done, src_half, dst_done, dst_half, blk_done, cell_done, irq_abort, addr_err};
	wire [7:0] ie_new = reg_wdata[`EVT_IE_MSB:`EVT_IE_LSB];
	wire [7:0] flag_wr = reg_wdata[`EVT_FL_MSB:0];
	wire [7:0] ie_live = wr_evt ? ie_new : ie_reg;
	wire [7:0] irq_term;
	genvar gi;

	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_evt
			assign flag_next[gi] = (wr_evt ? flag_wr[gi] : flag_reg[gi]) | evt_set[gi];
			assign irq_term[gi] = flag_next[gi] & ie_live[gi];
		end
	endgenerate

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ie_reg <= `RST_ZERO8;
			flag_reg <= `RST_ZERO8;
			chan_irq <= 1'b0;
		end else begin
			if (wr_evt) begin
				ie_reg <= ie_new;
			end
			flag_reg <= flag_next;
			chan_irq <= |irq_term;
		end
	end

	// ----------------------------------------
	// Start addresses
	// ----------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ssa_reg <= `RST_ZERO32;
		end else if (reg_wr && (reg_addr == `OFS_SSA)) begin
			ssa_reg <= reg_wdata;
		end
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dsa_reg <= `RST_ZERO32;
		end else if (reg_wr && (reg_addr == `OFS_DSA)) begin
			dsa_reg <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	// Sizes are 16 bits; the upper half of the word is dropped
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ssiz_reg <= `RST_ZERO16;
			dsiz_reg <= `RST_ZERO16;
			csiz_reg <= `RST_ZERO16;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFS_SSIZ: ssiz_reg <= reg_wdata[15:0];
				`OFS_DSIZ: dsiz_reg <= reg_wdata[15:0];
				`OFS_CSIZ: csiz_reg <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Control
	// ----------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_abt_reg <= 1'b0;
			pat_abt_reg <= 1'b0;
			airq_reg <= `RST_AIRQ;
		end else if (wr_ctrl) begin
			irq_abt_reg <= reg_wdata[`CTRL_IRQ_ABT];
			pat_abt_reg <= reg_wdata[`CTRL_PAT_ABT];
			airq_reg <= reg_wdata[`CTRL_AIRQ_MSB:`CTRL_AIRQ_LSB];
		end
	end

	// ----------------------------------------
	// Channel on
	// ----------------------------------------
	// A pattern abort wins over a software write in the same cycle
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			on_reg <= 1'b0;
		end else if (pat_abort) begin
			on_reg <= 1'b0;
		end else if (!stop && wr_ctrl) begin
			on_reg <= reg_wdata[`CTRL_ON];
		end
	end

	// ----------------------------------------
	// Channel state
	// ----------------------------------------
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	always @* begin
		state_next = active_reg;
		case (active_reg)
			ST_IDLE: begin
				if (!wr_ctrl && start_evt && on_reg) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (end_blk) begin
					state_next = ST_IDLE;
				end else if (wr_ctrl) begin
					if (!reg_wdata[`CTRL_ON]) begin
						state_next = ST_IDLE;
					end
				end else if (step && cell_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			active_reg <= ST_IDLE;
		end else begin
			active_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Pointers
	// ----------------------------------------
	// Pointers wrap to zero at their size so the next block restarts cleanly
	// A control write in the same cycle as a byte holds the pointers still
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sptr_reg <= `RST_ZERO16;
		end else if (end_blk) begin
			sptr_reg <= `RST_ZERO16;
		end else if (step && !wr_ctrl) begin
			sptr_reg <= src_done ? `RST_ZERO16 : sptr_inc[15:0];
		end
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dptr_reg <= `RST_ZERO16;
		end else if (end_blk) begin
			dptr_reg <= `RST_ZERO16;
		end else if (step && !wr_ctrl) begin
			dptr_reg <= dst_done ? `RST_ZERO16 : dptr_inc[15:0];
		end
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cptr_reg <= `RST_ZERO16;
			moved_reg <= 17'h0_0000;
		end else if (end_blk) begin
			cptr_reg <= `RST_ZERO16;
			moved_reg <= 17'h0_0000;
		end else if (step && !wr_ctrl) begin
			cptr_reg <= cell_done ? `RST_ZERO16 : cptr_inc[15:0];
			moved_reg <= moved_inc;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
			abort_pulse <= 1'b0;
		end else begin
			busy <= active_reg;
			abort_pulse <= irq_abort || pat_abort;
		end
	end

	// Addresses lag the pointers by one cycle
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			src_addr_out <= `RST_ZERO32;
			dst_addr_out <= `RST_ZERO32;
		end else begin
			src_addr_out <= ssa_reg + {16'h0000, sptr_reg};
			dst_addr_out <= dsa_reg + {16'h0000, dptr_reg};
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always @* begin
		case (reg_addr)
			`OFS_EVT: begin
				rdata_next = {8'h00, ie_reg, 8'h00, flag_reg};
			end
			`OFS_SSA: begin
				rdata_next = ssa_reg;
			end
			`OFS_DSA: begin
				rdata_next = dsa_reg;
			end
			`OFS_SSIZ: begin
				rdata_next = {16'h0000, ssiz_reg};
			end
			`OFS_DSIZ: begin
				rdata_next = {16'h0000, dsiz_reg};
			end
			`OFS_CSIZ: begin
				rdata_next = {16'h0000, csiz_reg};
			end
			`OFS_CTRL: begin
				rdata_next = {16'h0000, airq_reg, 5'h00, pat_abt_reg, irq_abt_reg, on_reg};
			end
			`OFS_SPTR: begin
				rdata_next = {16'h0000, sptr_reg};
			end
			`OFS_DPTR: begin
				rdata_next = {16'h0000, dptr_reg};
			end
			default: begin
				rdata_next = `RST_ZERO32;
			end
		endcase
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= `RST_ZERO32;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : `RST_ZERO32;
		end
	end

endmodule

// ---- verif/dma_far_side.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Far side: moves one byte a cycle while the channel is busy and stall is low
// ----------------------------------------
// Stall models a slow memory; bytes after the cell ends are ignored by the channel
module dma_far_side (
	input wire clk_sys,
	input wire arst_n,
	input wire busy,
	input wire stall,
	output reg byte_moved
);
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			byte_moved <= 1'b0;
		else
			byte_moved <= busy && !stall;
	end
endmodule

// ---- verif/dma_chan_events_properties.sv ----
`timescale 1ns/100ps
module dma_chan_events_properties (
	input wire clk_sys,
	input wire arst_n,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire byte_moved,
	input wire irq_evt,
	input wire pattern_hit,
	input wire addr_invalid,
	input wire busy,
	input wire abort_pulse,
	input wire chan_irq
);
	// No event can touch the flags while this holds
	wire quiet = !(byte_moved | irq_evt | pattern_hit | addr_invalid | busy);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	unused_zero_a: assert property (reg_rd && reg_addr == 4'h0 |=>
		reg_rdata[31:24] == 8'h00 && reg_rdata[15:8] == 8'h00) else $error("unused event bits set");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data not idle");
	unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	irq_match_a: assert property (reg_rd && reg_addr == 4'h0 && quiet |=>
		chan_irq == |(reg_rdata[23:16] & reg_rdata[7:0])) else $error("irq level wrong");
	abort_single_a: assert property (abort_pulse |=> !abort_pulse) else $error("abort pulse too long");
	abort_cause_a: assert property (abort_pulse |-> $past(irq_evt | pattern_hit) ||
		$past(irq_evt | pattern_hit, 2)) else $error("abort without cause");
	addr_hold_a: assert property (reg_wr && (reg_addr == 4'h1 || reg_addr == 4'h2) ##1
		reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2)) else $error("address lost");
	enable_hold_a: assert property (reg_wr && reg_addr == 4'h0 && quiet ##1 reg_rd && reg_addr == 4'h0 && quiet
		|=> reg_rdata == ($past(reg_wdata, 2) & 32'h00ff_00ff)) else $error("event register lost");
endmodule
bind dma_chan_events dma_chan_events_properties u_dma_chan_events_properties (.clk_sys(clk_sys), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.byte_moved(byte_moved), .irq_evt(irq_evt), .pattern_hit(pattern_hit), .addr_invalid(addr_invalid),
	.busy(busy), .abort_pulse(abort_pulse), .chan_irq(chan_irq));

// ---- verif/dma_chan_events_tb.sv ----
`timescale 1ns/100ps
module dma_chan_events_tb;
	reg clk_sys = 1'b0;
	reg arst_n = 1'b0;
	reg [3:0] reg_addr = 4'h0;
	reg [31:0] reg_wdata = 32'h0000_0000;
	reg reg_wr = 1'b0, reg_rd = 1'b0, start_evt = 1'b0, irq_evt = 1'b0;
	reg pattern_hit = 1'b0, addr_invalid = 1'b0, stall = 1'b0;
	reg [7:0] irq_num = 8'h00;
	wire [31:0] reg_rdata, src_addr_out, dst_addr_out;
	wire byte_moved, busy, abort_pulse, chan_irq;
	int n_mismatch = 0, total_checks = 0, cycles = 0, aborts = 0, n;
	always #20 clk_sys = ~clk_sys;
	dma_chan_events u_dma_chan_events (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_evt(start_evt),
		.byte_moved(byte_moved), .irq_evt(irq_evt), .irq_num(irq_num), .pattern_hit(pattern_hit),
		.addr_invalid(addr_invalid), .busy(busy), .abort_pulse(abort_pulse), .src_addr_out(src_addr_out),
		.dst_addr_out(dst_addr_out), .chan_irq(chan_irq));
	dma_far_side u_dma_far_side (.clk_sys(clk_sys), .arst_n(arst_n), .busy(busy), .stall(stall),
		.byte_moved(byte_moved));
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (abort_pulse === 1'b1)
			aborts <= aborts + 1;
		if (cycles == 4000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task chk(input string nm, input [31:0] e, input [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Write strobe is dropped by the next rd or run call; a following wr keeps it high
	task wr(input [3:0] a, input [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
	endtask
	task rd(input [3:0] a, input [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask
	// Event kinds: 1 irq 4 then 5, 2 address error, 3 pattern hit
	task run(input int ev, input [31:0] e);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		start_evt <= 1'b1;
		@(posedge clk_sys);
		start_evt <= 1'b0;
		for (n = 0; busy !== 1'b1 && n < 20; n++)
			@(posedge clk_sys);
		irq_num <= 8'h04;
		irq_evt <= ev == 1;
		addr_invalid <= ev == 2;
		pattern_hit <= ev == 3;
		@(posedge clk_sys);
		irq_num <= 8'h05;
		addr_invalid <= 1'b0;
		pattern_hit <= 1'b0;
		@(posedge clk_sys);
		irq_evt <= 1'b0;
		for (n = 0; busy !== 1'b0 && n < 40; n++)
			@(posedge clk_sys);
		rd(4'h0, e);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(4'h0, 32'h0000_0000);
		chk("chan_irq", 32'h0000_0000, {31'h0, chan_irq});
		rd(4'h1, 32'h0000_0000);
		rd(4'h2, 32'h0000_0000);
		rd(4'h9, 32'h0000_0000);
		wr(4'h1, 32'ha5a5_0001);
		rd(4'h1, 32'ha5a5_0001);
		wr(4'h2, 32'h5a5a_f00c);
		rd(4'h2, 32'h5a5a_f00c);
		chk("src_addr_out", 32'ha5a5_0001, src_addr_out);
		chk("dst_addr_out", 32'h5a5a_f00c, dst_addr_out);
		wr(4'h0, 32'hffff_ff00);
		rd(4'h0, 32'h00ff_0000);
		wr(4'h5, 32'h0000_0002);
		wr(4'h3, 32'h0000_0004);
		wr(4'h4, 32'h0000_0004);
		wr(4'h6, 32'h0000_0001);
		run(0, 32'h00ff_0054);
		chk("chan_irq", 32'h0000_0001, {31'h0, chan_irq});
		chk("busy", 32'h0000_0000, {31'h0, busy});
		run(0, 32'h00ff_00fc);
		wr(4'h0, 32'h0000_00fc);
		rd(4'h0, 32'h0000_00fc);
		chk("chan_irq", 32'h0000_0000, {31'h0, chan_irq});
		wr(4'h0, 32'h00ff_0000);
		wr(4'h6, 32'h0000_0503);
		stall <= 1'b1;
		run(1, 32'h00ff_0002);
		chk("aborts", 32'h0000_0001, aborts);
		wr(4'h0, 32'h00ff_0000);
		run(2, 32'h00ff_0001);
		wr(4'h0, 32'h00ff_0000);
		wr(4'h6, 32'h0000_0005);
		run(3, 32'h00ff_0008);
		rd(4'h6, 32'h0000_0004);
		chk("aborts", 32'h0000_0002, aborts);
		stop_test();
	end
endmodule
